/* duc_pkg.sv */
// Shared constants, types and field layouts of the dual serial channel control block.
package duc_pkg;

    // ------------------------------------------------------------------
    // Register addressing
    // ------------------------------------------------------------------
    localparam logic [2:0] REG_MODE  = 3'h0;
    localparam logic [2:0] REG_STAT  = 3'h1;
    localparam logic [2:0] REG_CMD   = 3'h2;
    localparam logic [2:0] REG_HOLD  = 3'h3;
    localparam logic [1:0] ADR_GLOB  = 2'h3;
    localparam logic [3:0] ADR_OUTPUT_PIN_CONFIGURATION  = 4'hD;
    localparam logic [3:0] ADR_OPSET = 4'hE;
    localparam logic [3:0] ADR_OPCLR = 4'hF;

    // ------------------------------------------------------------------
    // Command codes, bit positions and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] CMD_PTR   = 3'h1;
    localparam logic [2:0] CMD_RXRST = 3'h2;
    localparam logic [2:0] CMD_TXRST = 3'h3;
    localparam logic [2:0] CMD_ERRST = 3'h4;
    localparam int         CMD_RXEN  = 0;
    localparam int         CMD_RXDIS = 1;
    localparam int         CMD_TXEN  = 2;
    localparam int         CMD_TXDIS = 3;
    localparam logic [7:0] MR_RST    = 8'h00;
    localparam logic [7:0] BAUD_RST  = 8'h00;
    localparam logic [7:0] OUTPUT_PIN_CONFIGURATION_RST  = 8'h00;
    localparam logic [7:0] OPR_RST   = 8'h00;
    localparam logic [7:0] RD_NONE   = 8'h00;
    localparam int         FIFO_DEPTH = 8;
    localparam int         AUX_RXA1  = 0;
    localparam int         AUX_TXA1  = 1;
    localparam int         AUX_TXA16 = 2;
    localparam int         AUX_RXB1  = 3;
    localparam int         AUX_TXB1  = 4;
    localparam int         AUX_CT    = 5;

    // Stop length in sixteenths of a bit period.
    localparam logic [5:0] STOP_LO   = 6'h09;
    localparam logic [5:0] STOP_HI   = 6'h11;
    localparam logic [5:0] STOP_HALF = 6'h08;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PAR_WITH  = 2'h0,
        PAR_FORCE = 2'h1,
        PAR_NONE  = 2'h2,
        PAR_MDROP = 2'h3
    } duc_par_t;

    typedef enum logic [1:0] {
        CHM_NORMAL = 2'h0,
        CHM_ECHO   = 2'h1,
        CHM_LOCAL  = 2'h2,
        CHM_REMOTE = 2'h3
    } duc_chm_t;

    typedef struct packed {
        logic       flow;
        logic       int_full;
        logic       block;
        duc_par_t   par;
        logic       odd;
        logic [1:0] bits;
        duc_chm_t   chm;
        logic [5:0] stop16;
    } duc_mode_t;

    typedef struct packed {
        logic       brk;
        logic       fe;
        logic       pe;
        logic [7:0] data;
    } duc_entry_t;

    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic [3:0] adr;
        logic [7:0] data;
        logic [5:0] aux;
    } duc_pins_t;

endpackage

/* duc_top.sv */
// Receive buffer and control, status and output port logic of the dual serial channel block.

// ----------------------------------------------------------------------
// Receive buffer
// ----------------------------------------------------------------------
module duc_fifo
    import duc_pkg::*;
#(
    parameter int W = 11,
    parameter int D = 8
) (
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    input  wire logic         flush_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0]   cnt_ff;
    logic [AW:0]   nxt_cnt;
    logic          push;
    logic          pop;

    assign push       = in_valid_i & in_ready_o;
    assign pop        = out_ready_i & out_valid_o;
    assign out_data_o = mem[rd_ff];

    always_comb begin
        nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        if (flush_i) begin
            nxt_cnt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ff       <= '0;
            rd_ff       <= '0;
            cnt_ff      <= '0;
            in_ready_o  <= 1'b0;
            out_valid_o <= 1'b0;
        end else begin
            wr_ff       <= flush_i ? rd_ff : wr_ff + AW'(push);
            rd_ff       <= flush_i ? rd_ff : rd_ff + AW'(pop);
            cnt_ff      <= nxt_cnt;
            in_ready_o  <= nxt_cnt != (AW+1)'(D);
            out_valid_o <= nxt_cnt != '0;
        end
    end
endmodule

// ----------------------------------------------------------------------
// Control block
// ----------------------------------------------------------------------
module duc_top
    import duc_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             cs_n_i,
    input  wire logic             rd_n_i,
    input  wire logic             wr_n_i,
    input  wire logic [3:0]       adr_i,
    input  wire logic [7:0]       d_i,
    input  wire logic [5:0]       aux_clk_i,
    input  wire logic [1:0]       rx_valid_i,
    input  wire duc_entry_t [1:0] rx_entry_i,
    input  wire logic [1:0]       rx_start_i,
    input  wire logic [1:0]       tx_take_i,
    input  wire logic [1:0]       tx_idle_i,
    output logic [7:0]            d_o,
    output logic                  d_oe_o,
    output logic [7:0]            op_o,
    output duc_mode_t [1:0]       mode_o,
    output logic [1:0]            rx_en_o,
    output logic [1:0]            tx_en_o,
    output logic [1:0]            rx_ready_o,
    output logic [1:0]            tx_valid_o,
    output logic [1:0][7:0]       tx_data_o,
    output logic [1:0][7:0]       baud_sel_o
);
    // Decodes both mode registers into the channel's working settings.
    function automatic duc_mode_t decode(input logic [7:0] m1, input logic [7:0] m2);
        duc_mode_t r;
        r.flow     = m1[7];
        r.int_full = m1[6];
        r.block    = m1[5];
        r.par      = duc_par_t'(m1[4:3]);
        r.odd      = m1[2];
        r.bits     = m1[1:0];
        r.chm      = duc_chm_t'(m2[7:6]);
        r.stop16   = m2[3] ? STOP_HI + {2'h0, m2[3:0]} : STOP_LO + {2'h0, m2[3:0]};
        if (!m2[3] && m1[1:0] == 2'h0) begin
            r.stop16 = r.stop16 + STOP_HALF;
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers and access detection
    // ------------------------------------------------------------------
    duc_pins_t s1_ff;
    duc_pins_t s2_ff;
    logic      rd_q_ff;
    logic      wr_q_ff;
    logic      rd_act;
    logic      wr_act;
    logic      rd_go;
    logic      wr_go;
    logic      glob;
    logic [2:0] reg_a;
    logic [1:0] sel;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_ff   <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
            s2_ff   <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
            rd_q_ff <= 1'b0;
            wr_q_ff <= 1'b0;
        end else begin
            s1_ff   <= '{cs_n_i, rd_n_i, wr_n_i, adr_i, d_i, aux_clk_i};
            s2_ff   <= s1_ff;
            rd_q_ff <= rd_act;
            wr_q_ff <= wr_act;
        end
    end

    assign rd_act = !s2_ff.cs_n && !s2_ff.rd_n;
    assign wr_act = !s2_ff.cs_n && !s2_ff.wr_n;
    assign rd_go  = rd_act && !rd_q_ff;
    assign wr_go  = wr_act && !wr_q_ff;
    assign glob   = s2_ff.adr[3:2] == ADR_GLOB;
    assign reg_a  = s2_ff.adr[2:0];
    assign sel    = glob ? 2'h0 : (s2_ff.adr[3] ? 2'h2 : 2'h1);

    // ------------------------------------------------------------------
    // Per-channel registers
    // ------------------------------------------------------------------
    logic [1:0][7:0] mr1_ff;
    logic [1:0][7:0] mr2_ff;
    logic [1:0]      ptr_ff;
    logic [1:0]      rx_en_ff;
    logic [1:0]      tx_en_ff;
    logic [1:0]      thr_full_ff;
    logic [1:0]      ovr_ff;
    logic [1:0]      mask_ff;
    logic [1:0][2:0] acc_ff;
    logic [1:0]      rts_neg_ff;
    logic [1:0]      cmd_go;
    logic [1:0]      hold_wr;
    logic [1:0]      pop;
    logic [1:0]      flush;
    logic [1:0]      head_ok;
    logic [1:0]      fifo_out_v;
    duc_entry_t [1:0] head;
    logic [1:0][7:0] stat;
    logic [2:0]      cmd;

    // Bit 7 of the command is unused and left out of the code.
    assign cmd = s2_ff.data[6:4];

    for (genvar c = 0; c < 2; c++) begin : g_ch
        assign cmd_go[c]  = wr_go && sel[c] && reg_a == REG_CMD;
        assign hold_wr[c] = wr_go && sel[c] && reg_a == REG_HOLD;
        assign pop[c]     = rd_go && sel[c] && reg_a == REG_HOLD && fifo_out_v[c];
        assign flush[c]   = cmd_go[c] && cmd == CMD_RXRST;
        assign head_ok[c] = fifo_out_v[c] && !mask_ff[c];

        duc_fifo #(
            .W ($bits(duc_entry_t)),
            .D (FIFO_DEPTH)
        ) u_fifo (
            .clk_i       (clk_i),
            .nrst_i      (nrst_i),
            .flush_i     (flush[c]),
            .in_valid_i  (rx_valid_i[c] && rx_en_ff[c]),
            .in_data_i   (rx_entry_i[c]),
            .in_ready_o  (rx_ready_o[c]),
            .out_valid_o (fifo_out_v[c]),
            .out_data_o  (head[c]),
            .out_ready_i (pop[c])
        );

        always_comb begin
            stat[c][7:5] = mode_o[c].block ? acc_ff[c]
                         : (head_ok[c] ? {head[c].brk, head[c].fe, head[c].pe} : 3'h0);
            stat[c][4]   = ovr_ff[c];
            stat[c][3]   = tx_en_ff[c] && !thr_full_ff[c] && tx_idle_i[c]
                           && mode_o[c].chm != CHM_ECHO;
            stat[c][2]   = tx_en_ff[c] && !thr_full_ff[c] && mode_o[c].chm != CHM_ECHO;
            stat[c][1]   = !rx_ready_o[c];
            stat[c][0]   = fifo_out_v[c];
        end
    end

    // Mode registers, baud select and the mode pointer.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mr1_ff     <= {2{MR_RST}};
            mr2_ff     <= {2{MR_RST}};
            ptr_ff     <= 2'h0;
            baud_sel_o <= {2{BAUD_RST}};
            mode_o     <= '0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (wr_go && sel[c] && reg_a == REG_MODE) begin
                    if (ptr_ff[c]) begin
                        mr2_ff[c] <= s2_ff.data;
                    end else begin
                        mr1_ff[c] <= s2_ff.data;
                    end
                end
                if (cmd_go[c] && cmd == CMD_PTR) begin
                    ptr_ff[c] <= 1'b0;
                end else if ((rd_go || wr_go) && sel[c] && reg_a == REG_MODE) begin
                    ptr_ff[c] <= 1'b1;
                end
                if (wr_go && sel[c] && reg_a == REG_STAT) begin
                    baud_sel_o[c] <= s2_ff.data;
                end
                mode_o[c] <= decode(mr1_ff[c], mr2_ff[c]);
            end
        end
    end

    // Enables, transmit holding register and receiver error state.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_en_ff    <= 2'h0;
            tx_en_ff    <= 2'h0;
            thr_full_ff <= 2'h0;
            tx_valid_o  <= 2'h0;
            tx_data_o   <= '0;
            ovr_ff      <= 2'h0;
            mask_ff     <= 2'h0;
            acc_ff      <= '0;
            rts_neg_ff  <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (flush[c] || (cmd_go[c] && s2_ff.data[CMD_RXDIS])) begin
                    rx_en_ff[c] <= 1'b0;
                end else if (cmd_go[c] && s2_ff.data[CMD_RXEN]) begin
                    rx_en_ff[c] <= 1'b1;
                end
                if ((cmd_go[c] && cmd == CMD_TXRST) || (cmd_go[c] && s2_ff.data[CMD_TXDIS])) begin
                    tx_en_ff[c] <= 1'b0;
                end else if (cmd_go[c] && s2_ff.data[CMD_TXEN]) begin
                    tx_en_ff[c] <= 1'b1;
                end
                // A load is only taken while the transmitter is enabled.
                tx_valid_o[c] <= hold_wr[c] && tx_en_ff[c];
                if (hold_wr[c] && tx_en_ff[c]) begin
                    tx_data_o[c]   <= s2_ff.data;
                    thr_full_ff[c] <= 1'b1;
                end else if (tx_take_i[c] || (cmd_go[c] && cmd == CMD_TXRST)) begin
                    thr_full_ff[c] <= 1'b0;
                end
                // A new overrun wins over a clear in the same cycle.
                if (rx_valid_i[c] && rx_en_ff[c] && !rx_ready_o[c]) begin
                    ovr_ff[c] <= 1'b1;
                end else if (cmd_go[c] && (cmd == CMD_ERRST || cmd == CMD_RXRST)) begin
                    ovr_ff[c] <= 1'b0;
                end
                if (cmd_go[c] && cmd == CMD_ERRST) begin
                    mask_ff[c] <= 1'b1;
                end else if (pop[c] || flush[c]) begin
                    mask_ff[c] <= 1'b0;
                end
                if (cmd_go[c] && (cmd == CMD_ERRST || cmd == CMD_RXRST)) begin
                    acc_ff[c] <= 3'h0;
                end else if (mode_o[c].block && head_ok[c]) begin
                    acc_ff[c] <= acc_ff[c] | {head[c].brk, head[c].fe, head[c].pe};
                end
                if (rx_start_i[c] && mode_o[c].flow && !rx_ready_o[c]) begin
                    rts_neg_ff[c] <= 1'b1;
                end else if (rx_ready_o[c]) begin
                    rts_neg_ff[c] <= 1'b0;
                end
            end
        end
    end

    assign rx_en_o = rx_en_ff;
    assign tx_en_o = tx_en_ff;

    // ------------------------------------------------------------------
    // Output port and read data
    // ------------------------------------------------------------------
    logic [7:0] output_pin_configuration_ff;
    logic [7:0] opr_ff;
    logic [7:0] nxt_op;
    logic [7:0] rd_val;
    logic [1:0] rx_int;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            output_pin_configuration_ff <= OUTPUT_PIN_CONFIGURATION_RST;
            opr_ff  <= OPR_RST;
        end else if (wr_go) begin
            case (s2_ff.adr)
                ADR_OUTPUT_PIN_CONFIGURATION:  output_pin_configuration_ff <= s2_ff.data;
                ADR_OPSET: opr_ff  <= opr_ff | s2_ff.data;
                ADR_OPCLR: opr_ff  <= opr_ff & ~s2_ff.data;
                default:   opr_ff  <= opr_ff;
            endcase
        end
    end

    assign rx_int[0] = mode_o[0].int_full ? stat[0][1] : stat[0][0];
    assign rx_int[1] = mode_o[1].int_full ? stat[1][1] : stat[1][0];

    always_comb begin
        // Pins are active low: a true status pulls low, and so does a set latch bit except on pins 0 and 1 while rts_neg_ff is set.
        nxt_op    = ~opr_ff;
        nxt_op[0] = ~(opr_ff[0] && !rts_neg_ff[0]);
        nxt_op[1] = ~(opr_ff[1] && !rts_neg_ff[1]);
        case (output_pin_configuration_ff[1:0])
            2'h1:    nxt_op[2] = s2_ff.aux[AUX_TXA16];
            2'h2:    nxt_op[2] = s2_ff.aux[AUX_TXA1];
            2'h3:    nxt_op[2] = s2_ff.aux[AUX_RXA1];
            default: nxt_op[2] = ~opr_ff[2];
        endcase
        case (output_pin_configuration_ff[3:2])
            2'h1:    nxt_op[3] = s2_ff.aux[AUX_CT];
            2'h2:    nxt_op[3] = s2_ff.aux[AUX_TXB1];
            2'h3:    nxt_op[3] = s2_ff.aux[AUX_RXB1];
            default: nxt_op[3] = ~opr_ff[3];
        endcase
        if (output_pin_configuration_ff[4]) nxt_op[4] = ~rx_int[0];
        if (output_pin_configuration_ff[5]) nxt_op[5] = ~rx_int[1];
        if (output_pin_configuration_ff[6]) nxt_op[6] = ~stat[0][2];
        if (output_pin_configuration_ff[7]) nxt_op[7] = ~stat[1][2];
    end

    always_comb begin
        rd_val = RD_NONE;
        if (!glob) begin
            case (reg_a)
                REG_MODE: rd_val = ptr_ff[sel[1]] ? mr2_ff[sel[1]] : mr1_ff[sel[1]];
                REG_STAT: rd_val = stat[sel[1]];
                REG_HOLD: rd_val = head[sel[1]].data;
                default:  rd_val = RD_NONE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            op_o   <= 8'hFF;
            d_o    <= RD_NONE;
            d_oe_o <= 1'b0;
        end else begin
            op_o   <= nxt_op;
            d_oe_o <= rd_act;
            if (rd_go) begin
                d_o <= rd_val;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    AST_PTR_ADV: assert property (
        (rd_go || wr_go) && sel[0] && reg_a == REG_MODE && !ptr_ff[0] |=> ptr_ff[0])
        else $error("mode pointer did not advance");
    AST_PTR_RST: assert property (cmd_go[1] && cmd == CMD_PTR |=> !ptr_ff[1])
        else $error("mode pointer not reset");
    AST_THR_IGN: assert property (
        hold_wr[0] && !tx_en_ff[0] |=> !tx_valid_o[0]
        && ($stable(thr_full_ff[0]) || $past(tx_take_i[0])))
        else $error("write taken by disabled transmitter");
    AST_TX_EN: assert property (
        cmd_go[0] && s2_ff.data[3:2] == 2'h1 && cmd != CMD_TXRST |=> tx_en_ff[0])
        else $error("transmitter enable lost");
    AST_RX_DIS: assert property (cmd_go[1] && s2_ff.data[CMD_RXDIS] |=> !rx_en_ff[1])
        else $error("receiver disable lost");
    // The decoded mode still shows its reset value one edge after reset is released.
    AST_STOP: assert property (
        $past(nrst_i) && mr2_ff[0][3] == 1'b0 && mr1_ff[0][1:0] == 2'h0
        && $stable(mr2_ff[0]) && $stable(mr1_ff[0])
        |=> mode_o[0].stop16 == 6'h11 + {3'h0, $past(mr2_ff[0][2:0])})
        else $error("stop length wrong");
    AST_ERR_CLR: assert property (cmd_go[0] && cmd == CMD_ERRST
        |=> acc_ff[0] == 3'h0 && stat[0][7:5] == 3'h0 ##1 1'b1)
        else $error("errors kept after reset");
    AST_CHAR_ERR: assert property (
        !mode_o[0].block && !fifo_out_v[0] |-> stat[0][7:5] == 3'h0)
        else $error("stale character error");
    AST_RTS_BACK: assert property (rts_neg_ff[0] && rx_ready_o[0]
        |=> !rts_neg_ff[0] && ($stable(opr_ff[0]) || $past(wr_go)))
        else $error("request-to-send not restored");
    AST_OP_LATCH: assert property (
        output_pin_configuration_ff[3:2] == 2'h0 |=> op_o[3] == !$past(opr_ff[3]))
        else $error("pin 3 not inverse of latch");

    COV_FULL:  cover property (!rx_ready_o[0] ##1 pop[0]);
    COV_TX:    cover property (hold_wr[1] && tx_en_ff[1] ##1 tx_valid_o[1]);
    COV_BLOCK: cover property (mode_o[0].block && acc_ff[0] != 3'h0 ##[1:20] cmd_go[0]);
endmodule

/* duc_remote.sv */
// Far-end model: remote serial station feeding the receive path and draining transmit.
module duc_remote
    import duc_pkg::*;
#(
    parameter int TAKE_DLY = 3
) (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic [1:0]  send_i,
    input  wire duc_entry_t  ent_i,
    input  wire logic [1:0]  tx_valid_i,
    output logic [1:0]       rx_valid_o,
    output duc_entry_t [1:0] rx_entry_o,
    output logic [1:0]       rx_start_o,
    output logic [1:0]       tx_take_o,
    output logic [1:0]       tx_idle_o
);
    logic [TAKE_DLY-1:0][1:0] pipe_ff;
    logic [1:0]               busy_ff;

    // The start bit is flagged one cycle before the finished character is offered.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_start_o <= 2'h0;
            rx_valid_o <= 2'h0;
            rx_entry_o <= '0;
            pipe_ff    <= '0;
            busy_ff    <= 2'h0;
        end else begin
            rx_start_o <= send_i;
            rx_valid_o <= rx_start_o;
            // Outside a transfer the entry lines carry junk, so stale data cannot pass.
            rx_entry_o <= (|rx_start_o) ? {ent_i, ent_i} : {~ent_i, ~ent_i};
            pipe_ff    <= {pipe_ff[TAKE_DLY-2:0], tx_valid_i};
            busy_ff    <= (busy_ff | tx_valid_i) & ~tx_take_o;
        end
    end

    assign tx_take_o = pipe_ff[TAKE_DLY-1];
    assign tx_idle_o = ~busy_ff;
endmodule

/* tb_top.sv */
// Self-checking bench for the dual serial channel control block.
module tb_top
    import duc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] m1; logic [7:0] m2; logic [5:0] st;} duc_tb_row_t;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic clk_i = 1'b0, nrst_i = 1'b0, cs_n_i = 1'b1, rd_n_i = 1'b1, wr_n_i = 1'b1;
    logic [3:0] adr_i = 4'h0;
    logic [7:0] d_i = 8'h00, q, d_o, op_o;
    logic [5:0] aux_clk_i = 6'h00;
    logic [1:0] send = 2'h0, rx_valid_i, rx_start_i, tx_take_i, tx_idle_i;
    logic [1:0] rx_en_o, tx_en_o, rx_ready_o, tx_valid_o;
    logic d_oe_o, doe;
    logic [1:0][7:0] tx_data_o, baud_sel_o;
    duc_entry_t ent = '0;
    duc_entry_t [1:0] rx_entry_i;
    duc_mode_t [1:0] mode_o;
    int err_count = 0, checked = 0, ntx = 0;
    duc_tb_row_t rows [7] = '{'{8'h00, 8'h00, 6'h11}, '{8'h20, 8'h07, 6'h18},
        '{8'hFF, 8'h47, 6'h10}, '{8'h08, 8'h4F, 6'h20}, '{8'h10, 8'h88, 6'h19},
        '{8'h67, 8'hC7, 6'h10}, '{8'h03, 8'h00, 6'h09}};

    duc_top duc_top_i (.clk_i, .nrst_i, .cs_n_i, .rd_n_i, .wr_n_i, .adr_i, .d_i, .aux_clk_i,
        .rx_valid_i, .rx_entry_i, .rx_start_i, .tx_take_i, .tx_idle_i, .d_o, .d_oe_o, .op_o,
        .mode_o, .rx_en_o, .tx_en_o, .rx_ready_o, .tx_valid_o, .tx_data_o, .baud_sel_o);
    duc_remote duc_remote_i (.clk_i, .nrst_i, .send_i(send), .ent_i(ent),
        .tx_valid_i(tx_valid_o), .rx_valid_o(rx_valid_i), .rx_entry_o(rx_entry_i),
        .rx_start_o(rx_start_i), .tx_take_o(tx_take_i), .tx_idle_o(tx_idle_i));

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (tx_valid_o[0] === 1'b1) ntx <= ntx + 1;
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // Strobes are synchronised, so address and data settle two clocks ahead.
    task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] dv);
        @(posedge clk_i);
        adr_i <= a;
        d_i <= dv;
        repeat (2) @(posedge clk_i);
        cs_n_i <= 1'b0;
        rd_n_i <= wr;
        wr_n_i <= !wr;
        repeat (5) @(posedge clk_i);
        q = d_o;
        doe = d_oe_o;
        {cs_n_i, rd_n_i, wr_n_i} <= 3'h7;
        repeat (5) @(posedge clk_i);
    endtask
    task automatic push(input duc_entry_t e);
        @(posedge clk_i);
        send <= 2'h1;
        ent <= e;
        @(posedge clk_i);
        send <= 2'h0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic final_report();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        #100us;
        err_count++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("op", 8'hFF, op_o);
        foreach (rows[i]) begin
            acc(1'b1, REG_CMD, 8'h10);
            acc(1'b1, REG_MODE, rows[i].m1);
            acc(1'b1, REG_MODE, rows[i].m2);
            chk("mode", {rows[i].m1, rows[i].m2[7:6], rows[i].st}, mode_o[0]);
        end
        acc(1'b1, REG_HOLD, 8'h11);
        chk("txv", 0, ntx);
        acc(1'b1, REG_CMD, 8'h05);
        chk("en", 4'h5, {rx_en_o, tx_en_o});
        acc(1'b1, REG_HOLD, 8'h3C);
        chk("txd", 9'h13C, {ntx[0], tx_data_o[0]});
        push({3'h4, 8'h41});
        push({3'h0, 8'h42});
        acc(1'b0, REG_STAT, 8'h00);
        chk("stat", 4'h9, {q[7:5], q[0]});
        acc(1'b0, REG_HOLD, 8'h00);
        chk("rhr", 8'h41, q);
        acc(1'b0, REG_STAT, 8'h00);
        chk("stat", 4'h1, {q[7:5], q[0]});
        acc(1'b1, REG_CMD, 8'h10);
        acc(1'b1, REG_MODE, 8'hA3);
        push({3'h2, 8'h43});
        push({3'h0, 8'h44});
        for (int k = 0; k < 3; k++) acc(1'b0, REG_HOLD, 8'h00);
        chk("rhr", 8'h44, q);
        acc(1'b0, REG_STAT, 8'h00);
        chk("stat", 4'h4, {q[7:5], q[0]});
        acc(1'b1, REG_CMD, 8'h40);
        acc(1'b0, REG_STAT, 8'h00);
        chk("stat", 4'h0, {q[7:5], q[0]});
        acc(1'b1, REG_CMD, 8'h02);
        chk("en", 4'h1, {rx_en_o, tx_en_o});
        acc(1'b1, ADR_OPSET, 8'h5A);
        chk("op", 8'hA5, op_o);
        acc(1'b1, ADR_OPCLR, 8'h0A);
        acc(1'b1, ADR_OUTPUT_PIN_CONFIGURATION, 8'h45);
        chk("op", 8'hA3, op_o);
        aux_clk_i <= 6'h24;
        repeat (6) @(posedge clk_i);
        chk("op", 8'hAF, op_o);
        acc(1'b1, REG_STAT, 8'hA5);
        chk("baud", 8'hA5, baud_sel_o[0]);
        acc(1'b1, 4'h8, 8'h1F);
        chk("modeb", 8'h1F, mode_o[1][15:8]);
        acc(1'b1, ADR_OPSET, 8'h01);
        acc(1'b1, REG_CMD, 8'h01);
        for (int k = 0; k < 9; k++) push('0);
        acc(1'b0, REG_STAT, 8'h00);
        chk("full", 5'h1F, {doe, q[4], q[1:0], op_o[0]});
        acc(1'b0, REG_HOLD, 8'h00);
        chk("rts", 2'h2, {rx_ready_o[0], op_o[0]});
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("rst", 32'h7F800000, {op_o, d_oe_o, rx_en_o, tx_en_o, rx_ready_o, mode_o[0]});
        nrst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("rdy", 2'h3, rx_ready_o);
        final_report();
    end
endmodule
